// [ltsg_status_group.sv]
// Link test status group: condition, transition filters, event latch, masks and summaries.
// What this block does
// - Enabled set calibration events drive parent summary bit 8 high.
// - Masks are written as plain binary bit-weight sums, e.g. 520 = bits 9, 3.
// - Reading a mask returns the last written value and leaves it alone.
// - Without the test option present, every group bit reads zero except the calibration mask.
// - Test group summary drives parent questionable bit 12.
// - Condition bit 0 flags no test clock for over three seconds in a test.
// - Condition bit 1 flags test data constant over 200 test clocks in a test.
// - Condition bit 2 flags loss of tester synchronisation.
// - Condition bits 3 to 10 and 15 always read zero.
// - Condition bit 11 follows downconverter or demodulator lock loss.
// - Condition bit 12 follows demodulator amplitude out of range.
// - Condition bit 13 follows missing broadcast or traffic channel sync.
// - Condition bit 14 follows missing traffic channel midamble.
// - Condition register is live and read-only; reads return the set bits.
// - Rising edges latch through rise filter, falling through fall filter.
// - Latched event bits hold until cleared, even after the condition reverts.
// - Reading the event latch returns it, then clears it.
// - Test summary is high when any event bit and its mask bit are set.
`timescale 1ns/1ps
module ltsg_status_group
  import ltsg_pkg::*;
#(
  parameter int unsigned CLOCK_LOSS_LIMIT = CLOCK_LOSS_CYCLES,
  parameter int unsigned STUCK_LIMIT = STUCK_PERIODS
) (
  input wire logic CLK,
  input wire logic RESET_N,
  input wire logic TEST_CLOCK_INPUT,
  input wire logic TEST_DATA_INPUT,
  input wire logic SYNC_LOST,
  input wire logic LOCK_LOST,
  input wire logic AMP_OUT_OF_RANGE,
  input wire logic CHANNEL_SYNC_MISSING,
  input wire logic MIDAMBLE_MISSING,
  input wire logic OPTION_PRESENT,
  input wire logic TEST_ACTIVE,
  input wire logic [15:0] CAL_EVENT,
  input wire ltsg_cmd_t CMD,
  output ltsg_rsp_t RSP,
  output logic QUES_TEST_SUMMARY,
  output logic QUES_CAL_SUMMARY
);
  ltsg_state_t st_r;
  ltsg_state_t st_nxt;
  logic clock_lost;
  logic data_stuck;
  logic option_ok;
  logic test_run;
  logic clk_edge;
  logic data_change;
  logic read_event;
  logic [15:0] set_vec;

  // Qualifiers taken from the second synchroniser stage only.
  assign option_ok = st_r.pin_s2[PIN_OPTION];
  assign test_run = option_ok && st_r.pin_s2[PIN_TEST_ACTIVE];
  assign clk_edge = st_r.pin_s2[PIN_TEST_CLOCK] && !st_r.clk_prev;
  assign data_change = st_r.pin_s2[PIN_TEST_DATA] ^ st_r.data_prev;
  assign read_event = CMD.valid && !CMD.write && (CMD.sel == SEL_EVENT_LATCH);

  // clock loss timer
  // Counts system cycles since the last test clock edge; sized to the full three seconds.
  ltsg_idle_timer #(
    .W(TIMER_W),
    .LIMIT(TIMER_W'(CLOCK_LOSS_LIMIT))
  ) u_clock_loss (
    .clk(CLK),
    .reset_n(RESET_N),
    .run(test_run),
    .tick(1'b1),
    .restart(clk_edge),
    .expired(clock_lost)
  );

  // stuck data timer
  // Counts test clock edges since the data line last moved.
  ltsg_idle_timer #(
    .W(TIMER_W),
    .LIMIT(TIMER_W'(STUCK_LIMIT))
  ) u_data_stuck (
    .clk(CLK),
    .reset_n(RESET_N),
    .run(test_run),
    .tick(clk_edge),
    .restart(data_change),
    .expired(data_stuck)
  );

  // Next-state logic for the whole group.
  always_comb begin
    st_nxt = st_r;
    set_vec = '0;
    // Two-stage synchronisers for all pins; stage one feeds stage two only.
    st_nxt.pin_s1 = {TEST_ACTIVE, OPTION_PRESENT, MIDAMBLE_MISSING, CHANNEL_SYNC_MISSING,
                     AMP_OUT_OF_RANGE, LOCK_LOST, SYNC_LOST, TEST_DATA_INPUT, TEST_CLOCK_INPUT};
    st_nxt.pin_s2 = st_r.pin_s1;
    st_nxt.clk_prev = st_r.pin_s2[PIN_TEST_CLOCK];
    st_nxt.data_prev = st_r.pin_s2[PIN_TEST_DATA];

    st_nxt.cond = REG_RESET;
    st_nxt.cond[BIT_CLOCK_LOST] = clock_lost;
    st_nxt.cond[BIT_DATA_STUCK] = data_stuck;
    st_nxt.cond[BIT_SYNC_LOST] = st_r.pin_s2[PIN_SYNC_LOST];
    st_nxt.cond[BIT_LOCK_LOST] = st_r.pin_s2[PIN_LOCK_LOST];
    st_nxt.cond[BIT_AMP_RANGE] = st_r.pin_s2[PIN_AMP_RANGE];
    st_nxt.cond[BIT_CHAN_SYNC] = st_r.pin_s2[PIN_CHAN_SYNC];
    st_nxt.cond[BIT_MIDAMBLE] = st_r.pin_s2[PIN_MIDAMBLE];
    st_nxt.cond = st_nxt.cond & ~UNUSED_BITS;
    if (!option_ok) begin
      st_nxt.cond = REG_RESET;
    end

    set_vec = (st_nxt.cond & ~st_r.cond & st_r.rise_f) | (~st_nxt.cond & st_r.cond & st_r.fall_f);

    // clear on read
    // A transition in the same cycle as the read survives the clear.
    st_nxt.event_l = (read_event ? REG_RESET : st_r.event_l) | set_vec;
    if (!option_ok) begin
      st_nxt.event_l = REG_RESET;
    end

    // mask writes
    // The command data is the binary form of the decimal weight sum.
    if (CMD.valid && CMD.write) begin
      unique case (CMD.sel)
        SEL_RISE_FILTER: st_nxt.rise_f = CMD.data;
        SEL_FALL_FILTER: st_nxt.fall_f = CMD.data;
        SEL_EVENT_MASK: st_nxt.mask = CMD.data;
        SEL_CAL_MASK: st_nxt.cal_mask = CMD.data;
        default: st_nxt.rise_f = st_r.rise_f;
      endcase
    end

    // readback
    // Writes to the condition and latch are ignored; reads answer one cycle later.
    st_nxt.rsp.valid = CMD.valid && !CMD.write;
    st_nxt.rsp.data = REG_RESET;
    if (CMD.valid && !CMD.write) begin
      unique case (CMD.sel)
        SEL_CONDITION: st_nxt.rsp.data = st_r.cond;
        SEL_RISE_FILTER: st_nxt.rsp.data = st_r.rise_f;
        SEL_FALL_FILTER: st_nxt.rsp.data = st_r.fall_f;
        SEL_EVENT_LATCH: st_nxt.rsp.data = st_r.event_l;
        SEL_EVENT_MASK: st_nxt.rsp.data = st_r.mask;
        SEL_CAL_MASK: st_nxt.rsp.data = st_r.cal_mask;
        default: st_nxt.rsp.data = REG_RESET;
      endcase
      if (!option_ok && CMD.sel != SEL_CAL_MASK) begin
        st_nxt.rsp.data = REG_RESET;
      end
    end

    st_nxt.sum_test = option_ok && |(st_r.event_l & st_r.mask);
    st_nxt.sum_cal = |(CAL_EVENT & st_r.cal_mask);
  end

  // reset values
  // State register; everything, masks included, starts at zero.
  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Outputs straight from the state register.
  assign RSP = st_r.rsp;
  assign QUES_TEST_SUMMARY = st_r.sum_test;
  assign QUES_CAL_SUMMARY = st_r.sum_cal;

  // Checks on the group's own behaviour.
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RESET_N);

  property p_cal_summary;
    (|(CAL_EVENT & st_r.cal_mask)) |=> QUES_CAL_SUMMARY;
  endproperty
  a_cal_summary: assert property (p_cal_summary) else $error("cal summary missed");

  property p_mask_write;
    (CMD.valid && CMD.write && CMD.sel == SEL_EVENT_MASK && CMD.data == 16'h0208)
      |=> st_r.mask == 16'h0208;
  endproperty
  a_mask_write: assert property (p_mask_write) else $error("mask write 520 lost");

  property p_mask_read;
    (CMD.valid && !CMD.write && CMD.sel == SEL_CAL_MASK)
      |=> RSP.valid && RSP.data == $past(st_r.cal_mask) && st_r.cal_mask == $past(st_r.cal_mask);
  endproperty
  a_mask_read: assert property (p_mask_read) else $error("mask readback wrong");

  property p_no_option;
    (!option_ok) [*2] |-> st_r.cond == REG_RESET && st_r.event_l == REG_RESET ##1 !QUES_TEST_SUMMARY;
  endproperty
  a_no_option: assert property (p_no_option) else $error("bits set without option");

  property p_test_summary;
    (option_ok && |(st_r.event_l & st_r.mask)) |=> QUES_TEST_SUMMARY;
  endproperty
  a_test_summary: assert property (p_test_summary) else $error("test summary missed");

  property p_summary_clear;
    !(|(st_r.event_l & st_r.mask)) |=> !QUES_TEST_SUMMARY;
  endproperty
  a_summary_clear: assert property (p_summary_clear) else $error("test summary stuck");

  property p_unused_zero;
    (st_r.cond & UNUSED_BITS) == REG_RESET;
  endproperty
  a_unused_zero: assert property (p_unused_zero) else $error("unused condition bit set");

  property p_timing_in_test;
    (st_r.cond[BIT_CLOCK_LOST] || st_r.cond[BIT_DATA_STUCK]) |-> $past(test_run, 2);
  endproperty
  a_timing_in_test: assert property (p_timing_in_test) else $error("timing fault outside test");

  property p_cond_read;
    (CMD.valid && !CMD.write && CMD.sel == SEL_CONDITION && option_ok) |=> RSP.data == $past(st_r.cond);
  endproperty
  a_cond_read: assert property (p_cond_read) else $error("condition read wrong");

  property p_filter;
    (option_ok && st_nxt.pin_s2[PIN_OPTION] && set_vec != REG_RESET)
      |=> (st_r.event_l & $past(set_vec)) == $past(set_vec);
  endproperty
  a_filter: assert property (p_filter) else $error("filtered edge not latched");

  property p_sticky;
    (option_ok && st_nxt.pin_s2[PIN_OPTION] && !read_event)
      |=> (st_r.event_l & $past(st_r.event_l)) == $past(st_r.event_l);
  endproperty
  a_sticky: assert property (p_sticky) else $error("event bit dropped");

  property p_read_clear;
    read_event |=> RSP.data == ($past(option_ok) ? $past(st_r.event_l) : REG_RESET)
      && (st_r.event_l & ~$past(set_vec)) == REG_RESET;
  endproperty
  a_read_clear: assert property (p_read_clear) else $error("event read did not clear");

  property p_reset_zero;
    !$past(RESET_N) |-> st_r.mask == REG_RESET && st_r.rise_f == REG_RESET && st_r.event_l == REG_RESET;
  endproperty
  a_reset_zero: assert property (p_reset_zero) else $error("register not zero after reset");

  // Condition bits follow their synchronised pins one edge later while the option is fitted.
  property p_sync_follow;
    option_ok |=> st_r.cond[BIT_SYNC_LOST] == $past(st_r.pin_s2[PIN_SYNC_LOST]);
  endproperty
  a_sync_follow: assert property (p_sync_follow) else $error("sync lost bit wrong");

  property p_lock_follow;
    option_ok |=> st_r.cond[BIT_LOCK_LOST] == $past(st_r.pin_s2[PIN_LOCK_LOST]);
  endproperty
  a_lock_follow: assert property (p_lock_follow) else $error("lock lost bit wrong");

  property p_amp_follow;
    option_ok |=> st_r.cond[BIT_AMP_RANGE] == $past(st_r.pin_s2[PIN_AMP_RANGE]);
  endproperty
  a_amp_follow: assert property (p_amp_follow) else $error("amplitude bit wrong");

  property p_chan_follow;
    option_ok |=> st_r.cond[BIT_CHAN_SYNC] == $past(st_r.pin_s2[PIN_CHAN_SYNC]);
  endproperty
  a_chan_follow: assert property (p_chan_follow) else $error("channel sync bit wrong");

  property p_midamble_follow;
    option_ok |=> st_r.cond[BIT_MIDAMBLE] == $past(st_r.pin_s2[PIN_MIDAMBLE]);
  endproperty
  a_midamble_follow: assert property (p_midamble_follow) else $error("midamble bit wrong");

  // A test clock edge or a data change clears the matching timer fault two edges on.
  property p_clock_seen;
    clk_edge |-> ##2 !st_r.cond[BIT_CLOCK_LOST];
  endproperty
  a_clock_seen: assert property (p_clock_seen) else $error("clock lost bit kept after edge");

  property p_data_moved;
    data_change |-> ##2 !st_r.cond[BIT_DATA_STUCK];
  endproperty
  a_data_moved: assert property (p_data_moved) else $error("data stuck bit kept after change");

  // Summaries and answers only rise for a reason; a stray pulse would mislead the parent register.
  property p_test_source;
    QUES_TEST_SUMMARY
      |-> $past(option_ok) && $past(|(st_r.event_l & st_r.mask));
  endproperty
  a_test_source: assert property (p_test_source) else $error("test summary without cause");

  property p_cal_clear;
    !(|(CAL_EVENT & st_r.cal_mask)) |=> !QUES_CAL_SUMMARY;
  endproperty
  a_cal_clear: assert property (p_cal_clear) else $error("cal summary stuck");

  property p_rsp_pulse;
    !(CMD.valid && !CMD.write) |=> !RSP.valid;
  endproperty
  a_rsp_pulse: assert property (p_rsp_pulse) else $error("answer without a read");

  // With the option absent only the calibration mask may answer with a nonzero word.
  property p_hidden;
    !option_ok
      |=> !RSP.valid || RSP.data == REG_RESET || $past(CMD.sel) == SEL_CAL_MASK;
  endproperty
  a_hidden: assert property (p_hidden) else $error("test register visible without option");

  // The latch only gains bits where the condition really moved, so unused bits stay clear there too.
  property p_new_event;
    !read_event
      |=> (st_r.event_l & ~$past(st_r.event_l) & ~(st_r.cond ^ $past(st_r.cond))) == REG_RESET;
  endproperty
  a_new_event: assert property (p_new_event) else $error("event without transition");

  property p_unused_latch;
    (st_r.event_l & UNUSED_BITS) == REG_RESET;
  endproperty
  a_unused_latch: assert property (p_unused_latch) else $error("unused event bit set");

  // Outputs are quiet on the first edge after reset, before any command can be answered.
  property p_reset_out;
    !$past(RESET_N)
      |-> !RSP.valid && !QUES_TEST_SUMMARY && !QUES_CAL_SUMMARY;
  endproperty
  a_reset_out: assert property (p_reset_out) else $error("output set after reset");
endmodule

// [ltsg_pkg_timer.sv]
// Shared constants and types for the link test status group, plus its idle timer.
`timescale 1ns/1ps
package ltsg_pkg;
  // Register selectors on the status command port.
  localparam logic [2:0] SEL_CONDITION = 3'h0;
  localparam logic [2:0] SEL_RISE_FILTER = 3'h1;
  localparam logic [2:0] SEL_FALL_FILTER = 3'h2;
  localparam logic [2:0] SEL_EVENT_LATCH = 3'h3;
  localparam logic [2:0] SEL_EVENT_MASK = 3'h4;
  localparam logic [2:0] SEL_CAL_MASK = 3'h5;
  // Condition bit positions.
  localparam int BIT_CLOCK_LOST = 0;
  localparam int BIT_DATA_STUCK = 1;
  localparam int BIT_SYNC_LOST = 2;
  localparam int BIT_LOCK_LOST = 11;
  localparam int BIT_AMP_RANGE = 12;
  localparam int BIT_CHAN_SYNC = 13;
  localparam int BIT_MIDAMBLE = 14;
  // Bits 3 to 10 and bit 15 never set.
  localparam logic [15:0] UNUSED_BITS = 16'h87F8;
  localparam logic [15:0] REG_RESET = 16'h0000;
  // Pin indexes into the synchroniser vectors.
  localparam int PIN_TEST_CLOCK = 0;
  localparam int PIN_TEST_DATA = 1;
  localparam int PIN_SYNC_LOST = 2;
  localparam int PIN_LOCK_LOST = 3;
  localparam int PIN_AMP_RANGE = 4;
  localparam int PIN_CHAN_SYNC = 5;
  localparam int PIN_MIDAMBLE = 6;
  localparam int PIN_OPTION = 7;
  localparam int PIN_TEST_ACTIVE = 8;
  localparam int PIN_COUNT = 9;
  // Timing: the clock-loss limit in seconds and in cycles at 125 MHz.
  localparam int unsigned CLK_HZ = 125_000_000;
  localparam int unsigned CLOCK_LOSS_S = 3;
  localparam int unsigned CLOCK_LOSS_CYCLES = CLOCK_LOSS_S * CLK_HZ;
  localparam int unsigned STUCK_PERIODS = 200;
  localparam int TIMER_W = 29;
  // Command and answer carriers.
  typedef struct packed {
    logic valid;
    logic write;
    logic [2:0] sel;
    logic [15:0] data;
  } ltsg_cmd_t;
  typedef struct packed {
    logic valid;
    logic [15:0] data;
  } ltsg_rsp_t;
  // Whole state of the status group.
  typedef struct packed {
    logic [PIN_COUNT-1:0] pin_s1;
    logic [PIN_COUNT-1:0] pin_s2;
    logic clk_prev;
    logic data_prev;
    logic [15:0] cond;
    logic [15:0] rise_f;
    logic [15:0] fall_f;
    logic [15:0] event_l;
    logic [15:0] mask;
    logic [15:0] cal_mask;
    logic sum_test;
    logic sum_cal;
    ltsg_rsp_t rsp;
  } ltsg_state_t;
endpackage

// Counts ticks while running; expires once more than LIMIT ticks pass without a restart.
module ltsg_idle_timer
  import ltsg_pkg::*;
#(
  parameter int W = TIMER_W,
  parameter logic [W-1:0] LIMIT = W'(STUCK_PERIODS)
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic run,
  input wire logic tick,
  input wire logic restart,
  output logic expired
);
  typedef struct packed {
    logic [W-1:0] cnt;
    logic expired;
  } ltsg_idle_state_t;

  ltsg_idle_state_t st_r;
  ltsg_idle_state_t st_nxt;

  // The counter saturates one past the limit so it never wraps back to clear.
  always_comb begin
    st_nxt = st_r;
    if (!run || restart) begin
      st_nxt.cnt = '0;
    end else if (tick && st_r.cnt <= LIMIT) begin
      st_nxt.cnt = st_r.cnt + W'(1);
    end
    st_nxt.expired = run && !restart && (st_nxt.cnt > LIMIT);
  end

  // State register.
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign expired = st_r.expired;
endmodule

// [ltsg_status_group_bench.sv]
// Self-checking bench for the link test status group.
`timescale 1ns/1ps
module ltsg_status_group_bench
  import ltsg_pkg::*;
;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic tclk = 1'b0;
  logic tdat = 1'b0;
  logic [4:0] pv = 5'h00;
  logic opt = 1'b1;
  logic act = 1'b0;
  logic [15:0] cal = 16'h0000;
  ltsg_cmd_t cmd = '0;
  ltsg_rsp_t rsp;
  logic sum_t;
  logic sum_c;
  int err_count = 0;
  int checked = 0;
  int cycles = 0;
  int pos [5] = '{BIT_SYNC_LOST, BIT_LOCK_LOST, BIT_AMP_RANGE, BIT_CHAN_SYNC, BIT_MIDAMBLE};
  logic [15:0] acc;

  // Short limits keep the fault timers within a brief run.
  ltsg_status_group #(.CLOCK_LOSS_LIMIT(50), .STUCK_LIMIT(5)) dut_u (
    .CLK(clk), .RESET_N(rst_n), .TEST_CLOCK_INPUT(tclk), .TEST_DATA_INPUT(tdat),
    .SYNC_LOST(pv[0]), .LOCK_LOST(pv[1]), .AMP_OUT_OF_RANGE(pv[2]),
    .CHANNEL_SYNC_MISSING(pv[3]), .MIDAMBLE_MISSING(pv[4]), .OPTION_PRESENT(opt),
    .TEST_ACTIVE(act), .CAL_EVENT(cal), .CMD(cmd), .RSP(rsp),
    .QUES_TEST_SUMMARY(sum_t), .QUES_CAL_SUMMARY(sum_c)
  );

  // The clock toggles every half period of 4 ns.
  always #4 clk = ~clk;

  // A hang is cut short well past the expected run length.
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      err_count++;
      wrap_up();
    end
  end

  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cmp_bit(input logic got, input logic exp);
    cmp({15'h0000, got}, {15'h0000, exp});
  endtask

  // Commands are held for one cycle; writes give no answer.
  task automatic wr(input logic [2:0] s, input logic [15:0] d);
    @(negedge clk);
    cmd <= {1'b1, 1'b1, s, d};
    @(negedge clk);
    cmd <= '0;
  endtask

  // The answer stands in the cycle right after the taking edge.
  task automatic rd(input logic [2:0] s, input logic [15:0] exp);
    @(negedge clk);
    cmd <= {1'b1, 1'b0, s, 16'h0000};
    @(negedge clk);
    cmd <= '0;
    cmp_bit(rsp.valid, 1'b1);
    cmp(rsp.data, exp);
  endtask

  task automatic idle(input int n);
    repeat (n) @(negedge clk);
  endtask

  task automatic end_test(input string name);
    $display("test %s done, %0d mismatches so far", name, err_count);
  endtask

  task automatic wrap_up();
    $display("checks %0d, mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  initial begin
    idle(5);
    rst_n <= 1'b1;
    idle(4);
    for (int s = 0; s < 6; s++) rd(3'(s), 16'h0000);
    rd(3'h6, 16'h0000);
    end_test("reset");
    // Mask values come back unchanged, also on a second read.
    wr(SEL_EVENT_MASK, 16'h0208);
    wr(SEL_CAL_MASK, 16'h0208);
    wr(SEL_CONDITION, 16'hFFFF);
    rd(SEL_EVENT_MASK, 16'h0208);
    rd(SEL_EVENT_MASK, 16'h0208);
    rd(SEL_CAL_MASK, 16'h0208);
    rd(SEL_CONDITION, 16'h0000);
    end_test("masks");
    // Bit 11 is filtered on its falling edge only, bit 2 on both edges.
    wr(SEL_RISE_FILTER, 16'h7004);
    wr(SEL_FALL_FILTER, 16'h0804);
    rd(SEL_RISE_FILTER, 16'h7004);
    acc = 16'h0000;
    for (int i = 0; i < 5; i++) begin
      pv[i] = 1'b1;
      acc[pos[i]] = 1'b1;
      idle(4);
      rd(SEL_CONDITION, acc);
    end
    rd(SEL_EVENT_LATCH, 16'h7004);
    wr(SEL_EVENT_MASK, 16'h0800);
    pv <= 5'h00;
    idle(6);
    // Test summary follows the latched bit 11 fall event.
    cmp_bit(sum_t, 1'b1);
    rd(SEL_EVENT_LATCH, 16'h0804);
    rd(SEL_EVENT_LATCH, 16'h0000);
    idle(2);
    cmp_bit(sum_t, 1'b0);
    end_test("events");
    // Calibration summary is gated by its own mask.
    cal <= 16'h0008;
    idle(3);
    cmp_bit(sum_c, 1'b1);
    cal <= 16'h0004;
    idle(3);
    cmp_bit(sum_c, 1'b0);
    cal <= 16'h0200;
    idle(3);
    cmp_bit(sum_c, 1'b1);
    end_test("calibration");
    // Test clock runs with data held still, then stops.
    act <= 1'b1;
    for (int i = 0; i < 20; i++) begin
      tclk <= ~tclk;
      idle(4);
    end
    rd(SEL_CONDITION, 16'h0002);
    idle(70);
    rd(SEL_CONDITION, 16'h0003);
    tdat <= 1'b1;
    idle(4);
    rd(SEL_CONDITION, 16'h0001);
    act <= 1'b0;
    idle(4);
    rd(SEL_CONDITION, 16'h0000);
    end_test("tester");
    // Without the option fitted the group reads zero, except the calibration mask.
    opt <= 1'b0;
    pv[0] <= 1'b1;
    idle(5);
    rd(SEL_CONDITION, 16'h0000);
    rd(SEL_EVENT_LATCH, 16'h0000);
    rd(SEL_EVENT_MASK, 16'h0000);
    rd(SEL_CAL_MASK, 16'h0208);
    end_test("option");
    wrap_up();
  end
endmodule
